/* src/mric_top.sv */
// macrocell register block with wishbone configuration and security
//
// The implementer's own choices: the Wishbone slave port and the address map.
`timescale 1ns/10ps
module mric_top
  import mric_pkg::*;
#(
  parameter int N_CELLS = 12,
  parameter int ARRAY_DEPTH = 16
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // shared init terms from the array
  input wire logic sync_preset_term,
  input wire logic async_reset_term,
  // per cell sum terms and pins
  input wire logic [N_CELLS-1:0] sum_in,
  input wire logic [N_CELLS-1:0] pin_in,
  output logic [N_CELLS-1:0] pin_out,
  // two device clock inputs, sampled
  input wire logic dev_clk_a,
  input wire logic dev_clk_b,
  // state seen by the system
  output logic ready
);
  localparam int IDX_W = $clog2(ARRAY_DEPTH);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // byte-lane merge for a partial wishbone write
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
        res[8*b +: 8] = new_v[8*b +: 8];
    end
    return res;
  endfunction : lane_merge

  // widen a cell vector to a bus word, upper bits zero
  function automatic logic [31:0] widen(input logic [N_CELLS-1:0] v);
    logic [31:0] res;
    res = READ_ZERO;
    res[N_CELLS-1:0] = v;
    return res;
  endfunction : widen

  ////////////////////////////////////////////////////////////////////////
  // state

  logic ack_r;
  logic [31:0] rdat_r;
  logic secure_r;
  logic refused_r;
  logic por_done_r;
  logic [7:0] por_cnt_r;
  logic [N_CELLS-1:0] pol_r;
  logic [N_CELLS-1:0] clksel_r;
  logic [IDX_W-1:0] arr_idx_r;
  logic [31:0] array_mem [ARRAY_DEPTH];
  logic clk_a_meta_r, clk_a_sync_r, clk_a_old_r;
  logic clk_b_meta_r, clk_b_sync_r, clk_b_old_r;
  logic [N_CELLS-1:0] pin_meta_r, pin_sync_r;
  logic [N_CELLS-1:0] q;

  ////////////////////////////////////////////////////////////////////////
  // bus decode

  wire req = wb_cyc_i & wb_stb_i;
  // write lands on the edge where the master sees ack
  wire wr_go = req & wb_we_i & ack_r;
  wire wr_ctrl = wr_go & (wb_adr_i == REG_CTRL);
  wire wr_status = wr_go & (wb_adr_i == REG_STATUS);
  wire wr_pol = wr_go & (wb_adr_i == REG_POLARITY);
  wire wr_clksel = wr_go & (wb_adr_i == REG_CLKSEL);
  wire wr_idx = wr_go & (wb_adr_i == REG_ARR_IDX);
  wire wr_arr = wr_go & (wb_adr_i == REG_ARR_DATA);
  wire [31:0] ctrl_val = lane_merge(READ_ZERO, wb_dat_i, wb_sel_i);
  wire erase_go = wr_ctrl & ctrl_val[CTRL_ERASE];
  wire secure_go = wr_ctrl & ctrl_val[CTRL_SECURE] & ~erase_go;
  wire preload_req = wr_ctrl & ctrl_val[CTRL_PRELOAD];
  // a locked or still powering device ignores preload
  wire preload_go = preload_req & ~secure_r & por_done_r;
  wire [31:0] pol_nxt = lane_merge(widen(pol_r), wb_dat_i, wb_sel_i);
  wire [31:0] clksel_nxt = lane_merge(widen(clksel_r), wb_dat_i, wb_sel_i);
  wire [31:0] arr_word = array_mem[arr_idx_r];
  wire [31:0] arr_nxt = lane_merge(arr_word, wb_dat_i, wb_sel_i);

  // array readback hides the pattern once secured
  wire [31:0] arr_rd = secure_r ? ARRAY_DISCONNECTED : arr_word;
  wire [31:0] status_rd = READ_ZERO
    | (32'(secure_r) << STATUS_SECURED)
    | (32'(por_done_r) << STATUS_READY)
    | (32'(refused_r) << STATUS_REFUSED);
  wire [31:0] idx_rd = 32'(arr_idx_r);
  // unmapped offsets read zero and still answer
  wire [31:0] rd_mux =
    (wb_adr_i == REG_STATUS) ? status_rd :
    (wb_adr_i == REG_POLARITY) ? widen(pol_r) :
    (wb_adr_i == REG_CLKSEL) ? widen(clksel_r) :
    (wb_adr_i == REG_FLOPS) ? widen(q) :
    (wb_adr_i == REG_ARR_IDX) ? idx_rd :
    (wb_adr_i == REG_ARR_DATA) ? arr_rd : READ_ZERO;

  // one wait cycle, ack drops the cycle after it was given
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ack_r <= 1'b0;
      rdat_r <= READ_ZERO;
    end
    else
    begin
      ack_r <= req & ~ack_r;
      if (req & ~ack_r)
        rdat_r <= rd_mux;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  ////////////////////////////////////////////////////////////////////////
  // security, configuration and index

  // apart from rst, only an erase clears the lock, and it also wipes the pattern
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      secure_r <= 1'b0;
      refused_r <= 1'b0;
      pol_r <= {N_CELLS{CFG_UNPROG}};
      clksel_r <= {N_CELLS{CFG_UNPROG}};
      arr_idx_r <= '0;
    end
    else
    begin
      if (erase_go)
        secure_r <= 1'b0;
      else if (secure_go)
        secure_r <= 1'b1;
      // refusal sticks; a new refusal beats the clear
      if (preload_req & ~preload_go)
        refused_r <= 1'b1;
      else if (wr_status & ctrl_val[STATUS_REFUSED])
        refused_r <= 1'b0;
      if (erase_go)
        pol_r <= {N_CELLS{CFG_UNPROG}};
      else if (wr_pol & ~secure_r)
        pol_r <= pol_nxt[N_CELLS-1:0];
      if (erase_go)
        clksel_r <= {N_CELLS{CFG_UNPROG}};
      else if (wr_clksel & ~secure_r)
        clksel_r <= clksel_nxt[N_CELLS-1:0];
      if (wr_idx)
        arr_idx_r <= wb_dat_i[IDX_W-1:0];
    end
  end

  // pattern store, no reset; erase returns every cell to disconnected
  always_ff @(posedge core_clk)
  begin
    if (erase_go)
    begin
      for (int w = 0; w < ARRAY_DEPTH; w++)
        array_mem[w] <= ARRAY_DISCONNECTED;
    end
    else if (wr_arr & ~secure_r)
      array_mem[arr_idx_r] <= arr_nxt;
  end

  ////////////////////////////////////////////////////////////////////////
  // power-up delay

  // flops are already clear; this only holds off clocks and preload
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      por_cnt_r <= 8'h00;
      por_done_r <= 1'b0;
    end
    else if (!por_done_r)
    begin
      por_cnt_r <= por_cnt_r + 8'h01;
      por_done_r <= (por_cnt_r == 8'(POR_CYCLES - 1));
    end
  end

  assign ready = por_done_r;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  // device clocks and pins are foreign, two flops before any use
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      clk_a_meta_r <= 1'b0;
      clk_a_sync_r <= 1'b0;
      clk_a_old_r <= 1'b0;
      clk_b_meta_r <= 1'b0;
      clk_b_sync_r <= 1'b0;
      clk_b_old_r <= 1'b0;
      pin_meta_r <= '0;
      pin_sync_r <= '0;
    end
    else
    begin
      clk_a_meta_r <= dev_clk_a;
      clk_a_sync_r <= clk_a_meta_r;
      clk_a_old_r <= clk_a_sync_r;
      clk_b_meta_r <= dev_clk_b;
      clk_b_sync_r <= clk_b_meta_r;
      clk_b_old_r <= clk_b_sync_r;
      pin_meta_r <= pin_in;
      pin_sync_r <= pin_meta_r;
    end
  end

  // rising edges only; device clocks must stay well below core_clk / 4
  wire rise_a = clk_a_sync_r & ~clk_a_old_r;
  wire rise_b = clk_b_sync_r & ~clk_b_old_r;

  ////////////////////////////////////////////////////////////////////////
  // macrocells

  wire [N_CELLS-1:0] cap_v;

  genvar gi;
  generate
    for (gi = 0; gi < N_CELLS; gi++)
    begin : g_cell
      // unprogrammed select bit takes clock input a
      assign cap_v[gi] = por_done_r & (clksel_r[gi] ? rise_a : rise_b);
      // the same two terms reach every cell
      mric_cell u_cell
      (
        .core_clk(core_clk),
        .rst(rst),
        .async_reset_term(async_reset_term),
        .capture(cap_v[gi]),
        .sync_preset_term(sync_preset_term),
        .next_d(sum_in[gi]),
        .preload_go(preload_go),
        .preload_val(pin_sync_r[gi]),
        .q(q[gi])
      );
      // polarity sits after the flop, so init terms set the stored bit
      assign pin_out[gi] = pol_r[gi] ? q[gi] : ~q[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  sequence s_load_pre;
    preload_go && !async_reset_term;
  endsequence

  sequence s_sec_read;
    req && !wb_we_i && !ack_r && (wb_adr_i == REG_ARR_DATA) && secure_r;
  endsequence

  // preset lands in every capturing cell at the next edge
  property p_preset;
    (|cap_v) && sync_preset_term && !preload_go && !async_reset_term
    |=> async_reset_term || ((q & $past(cap_v)) == $past(cap_v));
  endproperty
  a_preset: assert property (p_preset)
    else $error("preset did not set the selected flops");

  // reset holds every flop low, preset or not
  property p_reset;
    async_reset_term |-> (q == '0);
  endproperty
  a_reset: assert property (p_reset)
    else $error("async reset did not clear the flops");

  // until the delay ends the flops stay clear and outputs show inverted polarity
  property p_por;
    !por_done_r |-> (q == '0) && (pin_out == ~pol_r);
  endproperty
  a_por: assert property (p_por)
    else $error("power-up state wrong");

  // ready comes exactly at the end of the count
  property p_por_time;
    !por_done_r && (por_cnt_r == 8'(POR_CYCLES - 1)) |=> por_done_r;
  endproperty
  a_por_time: assert property (p_por_time)
    else $error("power-up delay wrong length");

  // preload copies the synchronised pins into the flops
  property p_preload;
    s_load_pre |=> async_reset_term || (q == $past(pin_sync_r));
  endproperty
  a_preload: assert property (p_preload)
    else $error("preload value not stored");

  // a locked device keeps its flops through a preload request
  property p_no_preload;
    preload_req && secure_r && (cap_v == '0) && !async_reset_term
    |=> async_reset_term || $stable(q);
  endproperty
  a_no_preload: assert property (p_no_preload)
    else $error("preload took effect while secured");

  // secured array read answers with the disconnected value
  property p_hide;
    s_sec_read ##1 ack_r |-> (wb_dat_o == ARRAY_DISCONNECTED);
  endproperty
  a_hide: assert property (p_hide)
    else $error("secured readback exposed the pattern");

  // the lock only falls with an erase
  property p_lock;
    secure_r && !erase_go |=> secure_r;
  endproperty
  a_lock: assert property (p_lock)
    else $error("security bit cleared without erase");

  // every request is answered one cycle later
  property p_ack;
    req && !ack_r |=> ack_r ##1 !ack_r;
  endproperty
  a_ack: assert property (p_ack)
    else $error("wishbone answer timing wrong");

endmodule : mric_top

/* src/mric_pkg.sv */
// constants for the macrocell register init and protection block
package mric_pkg;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_POLARITY = 8'h08;
  localparam logic [7:0] REG_CLKSEL = 8'h0c;
  localparam logic [7:0] REG_FLOPS = 8'h10;
  localparam logic [7:0] REG_ARR_IDX = 8'h14;
  localparam logic [7:0] REG_ARR_DATA = 8'h18;
  // control bits (write one to act)
  localparam int CTRL_PRELOAD = 0;
  localparam int CTRL_SECURE = 1;
  localparam int CTRL_ERASE = 2;
  // status bits
  localparam int STATUS_SECURED = 0;
  localparam int STATUS_READY = 1;
  localparam int STATUS_REFUSED = 2;
  // erased configuration cells read as one
  localparam logic CFG_UNPROG = 1'b1;
  localparam logic [31:0] ARRAY_DISCONNECTED = 32'hffffffff;
  localparam logic [31:0] READ_ZERO = 32'h00000000;
  // power-up delay, longest time so rounded down
  localparam int CLK_PERIOD_NS = 50;
  localparam int POR_TIME_NS = 1000;
  localparam int POR_CYCLES = POR_TIME_NS / CLK_PERIOD_NS;
endpackage : mric_pkg

/* src/mric_cell.sv */
// one macrocell storage flop with shared preset and reset
`timescale 1ns/10ps
module mric_cell
(
  // clock and resets
  input wire logic core_clk,
  input wire logic rst,
  input wire logic async_reset_term,
  // load controls
  input wire logic capture,
  input wire logic sync_preset_term,
  input wire logic next_d,
  input wire logic preload_go,
  input wire logic preload_val,
  // stored bit
  output logic q
);
  // reset term clears without a clock and beats the preset
  always_ff @(posedge core_clk or posedge rst or posedge async_reset_term)
  begin
    if (rst)
      q <= 1'b0;
    else if (async_reset_term)
      q <= 1'b0;
    else if (preload_go)
      q <= preload_val;
    else if (capture)
      q <= sync_preset_term ? 1'b1 : next_d;
  end
endmodule : mric_cell

/* dv/mric_far.sv */
// far-side model: system logic driving device clocks and pins
`timescale 1ns/10ps
module mric_far
#(
  parameter int N_CELLS = 12
)
(
  // core clock that paces every change
  input wire logic core_clk,
  // device clock pins, still between pulses
  output logic dev_clk_a,
  output logic dev_clk_b,
  // pin levels offered for preload
  output logic [N_CELLS-1:0] pin_in
);
  ////////////////////////////////////////////////////////////////////
  logic [N_CELLS-1:0] last_r;

  // quiet pins at time zero
  initial
  begin
    dev_clk_a = 1'b0;
    dev_clk_b = 1'b0;
    last_r = '0;
    pin_in = '1;
  end

  ////////////////////////////////////////////////////////////////////
  // one pulse, three core cycles high and three low
  task automatic pulse(input logic on_a, input logic on_b);
    @(posedge core_clk);
    dev_clk_a <= on_a;
    dev_clk_b <= on_b;
    repeat (3) @(posedge core_clk);
    dev_clk_a <= 1'b0;
    dev_clk_b <= 1'b0;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
  endtask : pulse

  // tester puts a state, legal or not, on the pins
  task automatic present(input logic [N_CELLS-1:0] v);
    @(posedge core_clk);
    pin_in <= v;
    last_r = v;
  endtask : present

  // pins let go: inverse shown so a stale value never passes
  task automatic release_pins();
    @(posedge core_clk);
    pin_in <= ~last_r;
  endtask : release_pins
endmodule : mric_far

/* dv/mric_top_bench.sv */
// self-checking bench for the macrocell init and security block
`timescale 1ns/10ps
`define CHK(got, exp) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) \
    begin \
      miscompares++; \
      $display("mismatch at %0t: got %h want %h", $time, got, exp); \
    end \
  end
module mric_top_bench
  import mric_pkg::*;
;
  localparam int NC = 12;
  ////////////////////////////////////////////////////////////////////
  // stimulus and observed signals
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic sync_preset_term = 1'b0;
  logic async_reset_term = 1'b0;
  logic [NC-1:0] sum_in = 12'h000;
  logic [NC-1:0] pin_in;
  logic [NC-1:0] pin_out;
  logic dev_clk_a;
  logic dev_clk_b;
  logic ready;
  logic [31:0] rv;
  int miscompares = 0;
  int n_tests = 0;

  // 20 MHz core clock
  always #25 core_clk = ~core_clk;

  mric_top #(.N_CELLS(NC), .ARRAY_DEPTH(16)) uut (.core_clk(core_clk),
    .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .sync_preset_term(sync_preset_term),
    .async_reset_term(async_reset_term), .sum_in(sum_in),
    .pin_in(pin_in), .pin_out(pin_out), .dev_clk_a(dev_clk_a),
    .dev_clk_b(dev_clk_b), .ready(ready));

  mric_far #(.N_CELLS(NC)) far (.core_clk(core_clk),
    .dev_clk_a(dev_clk_a), .dev_clk_b(dev_clk_b), .pin_in(pin_in));

  ////////////////////////////////////////////////////////////////////
  // one classic cycle; ack and read data taken at the same rising edge
  task automatic wb(input logic we, input logic [7:0] adr,
                    input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    // no cycle count assumed; only the watchdog ends a lost answer
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (wb_ack_o !== 1'b1);
    rv = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    // taken at the first edge, answered at the second
    `CHK(n, 2)
    @(negedge core_clk);
  endtask : wb

  // verdict and end of run
  task automatic conclude();
    if (miscompares == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude

  ////////////////////////////////////////////////////////////////////
  // reset, wait out the power-up delay, check cleared state
  task automatic power_up();
    time t0;
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    t0 = $time;
    // pins are not all low, so a leaked preload shows in the flops
    wb(1'b1, REG_CTRL, 32'h1);
    while (ready !== 1'b1)
      @(negedge core_clk);
    `CHK(($time - t0) < POR_TIME_NS + CLK_PERIOD_NS, 1'b1)
    `CHK(pin_out, 12'h000)
    wb(1'b0, REG_FLOPS, 32'h0);
    `CHK(rv, 32'h00000000)
    wb(1'b0, REG_STATUS, 32'h0);
    `CHK(rv[STATUS_READY], 1'b1)
    `CHK(rv[STATUS_REFUSED], 1'b1)
    wb(1'b1, REG_STATUS, 32'h4);
    wb(1'b1, 8'h40, 32'h12345678);
    wb(1'b0, 8'h40, 32'h0);
    `CHK(rv, READ_ZERO)
  endtask : power_up

  // illegal state loaded from pins, then polarity flips the pins
  task automatic t_preload();
    far.present(12'ha5c);
    repeat (4) @(posedge core_clk);
    wb(1'b1, REG_CTRL, 32'h1);
    repeat (2) @(negedge core_clk);
    wb(1'b0, REG_FLOPS, 32'h0);
    `CHK(rv, 32'h00000a5c)
    `CHK(pin_out, 12'ha5c)
    wb(1'b1, REG_POLARITY, 32'h0000000f);
    `CHK(pin_out, 12'ha5c ^ 12'hff0)
    wb(1'b1, REG_POLARITY, 32'h00000fff);
    far.release_pins();
  endtask : t_preload

  // reset beats preset; preset waits for each cell's own clock
  task automatic t_preset();
    wb(1'b1, REG_CLKSEL, 32'h000000f0);
    @(posedge core_clk);
    async_reset_term <= 1'b1;
    sync_preset_term <= 1'b1;
    #1;
    `CHK(pin_out, 12'h000)
    far.pulse(1'b1, 1'b1);
    `CHK(pin_out, 12'h000)
    @(posedge core_clk);
    async_reset_term <= 1'b0;
    repeat (6) @(negedge core_clk);
    `CHK(pin_out, 12'h000)
    far.pulse(1'b1, 1'b0);
    `CHK(pin_out, 12'h0f0)
    far.pulse(1'b0, 1'b1);
    `CHK(pin_out, 12'hfff)
    @(posedge core_clk);
    sync_preset_term <= 1'b0;
    sum_in <= 12'h3c3;
    far.pulse(1'b1, 1'b1);
    `CHK(pin_out, 12'h3c3)
  endtask : t_preset

  // security hides the array, blocks preload, clears only by erase
  task automatic t_secure();
    wb(1'b1, REG_ARR_IDX, 32'h3);
    wb(1'b1, REG_ARR_DATA, 32'h5a5a0f0f);
    wb(1'b0, REG_ARR_DATA, 32'h0);
    `CHK(rv, 32'h5a5a0f0f)
    wb(1'b1, REG_CTRL, 32'h2);
    wb(1'b0, REG_STATUS, 32'h0);
    `CHK(rv[STATUS_SECURED], 1'b1)
    wb(1'b0, REG_ARR_DATA, 32'h0);
    `CHK(rv, ARRAY_DISCONNECTED)
    far.present(12'h00f);
    repeat (4) @(posedge core_clk);
    wb(1'b1, REG_CTRL, 32'h1);
    repeat (2) @(negedge core_clk);
    `CHK(pin_out, 12'h3c3)
    wb(1'b0, REG_STATUS, 32'h0);
    `CHK(rv[STATUS_REFUSED], 1'b1)
    wb(1'b1, REG_STATUS, 32'h7);
    wb(1'b1, REG_CTRL, 32'h0);
    wb(1'b0, REG_STATUS, 32'h0);
    `CHK(rv[STATUS_SECURED], 1'b1)
    `CHK(rv[STATUS_REFUSED], 1'b0)
    // programmer erases as it programs; erase wins over secure
    wb(1'b1, REG_CTRL, 32'h6);
    wb(1'b0, REG_STATUS, 32'h0);
    `CHK(rv[STATUS_SECURED], 1'b0)
    wb(1'b0, REG_ARR_DATA, 32'h0);
    `CHK(rv, 32'hffffffff)
    wb(1'b1, REG_CTRL, 32'h1);
    repeat (2) @(negedge core_clk);
    `CHK(pin_out, 12'h00f)
  endtask : t_secure

  ////////////////////////////////////////////////////////////////////
  // main sequence; second power-up clears a loaded state
  initial
  begin
    power_up();
    t_preload();
    t_preset();
    t_secure();
    power_up();
    conclude();
  end

  // watchdog well beyond the few hundred cycles the run needs
  initial
  begin
    #400000;
    miscompares++;
    conclude();
  end
endmodule : mric_top_bench
